// *** src/cfg_space_consts.vh ***
// Offsets, field positions, reset values and decode constants of the configuration header
`ifndef CFG_SPACE_CONSTS_VH
`define CFG_SPACE_CONSTS_VH
// Doubleword indices within the 64-byte header
`define CFG_IDX_ID 4'h0
`define CFG_IDX_CMDSTAT 4'h1
`define CFG_IDX_CLASS 4'h2
`define CFG_IDX_HDR 4'h3
`define CFG_IDX_BAR0 4'h4
`define CFG_IDX_SUBSYS 4'h8
`define CFG_IDX_INTR 4'hF
// Header spans sixteen doublewords
`define CFG_HDR_DWORDS 5'h10
// Bus commands
`define CMD_CFG_READ 4'hA
`define CMD_CFG_WRITE 4'hB
`define CMD_MEM_READ 4'h6
`define CMD_MEM_WRITE 4'h7
// Function numbers
`define FUNC_VIDEO 3'h0
`define FUNC_AUDIO 3'h1
// Command register writable bits
`define CMD_RW_MASK 16'h0146
`define CMD_BIT_MEM 1
`define CMD_BIT_MASTER 2
// Status fixed bits: medium select timing, fast back-to-back
`define STAT_FIXED 16'h0280
`define STAT_W1C_MASK 16'hF900
// Fixed field values
`define CLASS_CODE 24'h040000
`define HDR_TYPE_MULTI 8'h80
`define BAR0_LOW 12'h008
`define MAX_LAT 7'h28
`define MIN_GNT 9'h010
`define INT_PIN 8'h01
`define RESET_ZERO32 32'h00000000
`endif

// *** src/byte_merge.v ***
// Byte-enable merge of write data into a stored doubleword
`timescale 1ns/1ps
`default_nettype none
module byte_merge (
    // Stored and incoming data
    input wire [31:0] old_value,
    input wire [31:0] wr_data,
    input wire [3:0] be_n,
    // Merged result
    output wire [31:0] merged
);
    // Active-low enables pick each lane
    assign merged = {be_n[3] ? old_value[31:24] : wr_data[31:24],
                     be_n[2] ? old_value[23:16] : wr_data[23:16],
                     be_n[1] ? old_value[15:8] : wr_data[15:8],
                     be_n[0] ? old_value[7:0] : wr_data[7:0]};
endmodule
`default_nettype wire

// *** src/cfg_addr_decode.v ***
// Configuration cycle claim and function select decode
`timescale 1ns/1ps
`default_nettype none
`include "cfg_space_consts.vh"
module cfg_addr_decode (
    // Address phase inputs
    input wire idsel,
    input wire [31:0] addr,
    input wire [3:0] cmd,
    // Decode results
    output wire is_cfg,
    output wire cfg_write,
    output wire func_video,
    output wire [3:0] dword_idx
);
    wire cmd_cfg;
    wire type0;
    wire func_ok;
    assign cmd_cfg = (cmd == `CMD_CFG_READ) || (cmd == `CMD_CFG_WRITE);
    // Type 0 only: low two address bits zero, else ignored
    assign type0 = idsel && (addr[1:0] == 2'h0);
    // Claim only functions 0 and 1
    assign func_ok = (addr[10:8] == `FUNC_VIDEO) || (addr[10:8] == `FUNC_AUDIO);
    assign is_cfg = cmd_cfg && type0 && func_ok;
    assign cfg_write = cmd[0];
    assign func_video = (addr[10:8] == `FUNC_VIDEO);
    // Register index from address bits 5..2; bits 7..6, outside the header, are not part of it
    assign dword_idx = addr[5:2];
endmodule
`default_nettype wire

// *** src/pci_config_space_decode.v ***
// Function 0 configuration header target logic
//
// What this block does
// - A cycle is a configuration access only with device select high and address bits 1:0 zero.
// - Address bits 10:8 give the function number and zero selects the video function here.
// - The device is multifunction with two separate spaces and function 0 reports video class.
// - Address bits 7:2 select the register and byte enables pick the bytes.
// - Burst configuration reads and writes step through consecutive doublewords.
// - Writes to reserved, unimplemented or read-only bits complete quietly and are dropped.
// - Reads of reserved or unimplemented locations return zero.
// - Registers exist only within the 64-byte header, held as doublewords.
// - CIS pointer, self-test, cache line size, ROM base and user areas read as zero.
// - Configuration accesses are answered at all times.
// - A one-byte register sits in the byte lane of its byte address, except MAX_LAT, held in bits 31:25 so lane 3 reads 8'h50 rather than 7'h28.
// - Read/write bits clear to zero on bus reset unless another default applies.
// - Write-one-to-clear status bits clear on a one and ignore a zero.
// - Read-only fields return their fixed value whatever is written.
// - Configuration and memory spaces are separate, both at zero, told apart by select and command.
// - A command field of zero leaves the device off the bus except for configuration cycles.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_space_consts.vh"
module pci_config_space_decode #(
    parameter [15:0] DEVICE_ID = 16'h1234, // arbitrary value
    parameter [15:0] VENDOR_ID = 16'hABCD, // arbitrary value
    parameter [7:0] REVISION_ID = 8'h01 // arbitrary value
) (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Transaction from the bus interface (same clock)
    input wire frame_start,
    input wire idsel,
    input wire [31:0] addr,
    input wire [3:0] cmd,
    input wire data_valid,
    input wire last_data,
    input wire [31:0] wr_data,
    input wire [3:0] be_n,
    // Status events from the bus engine
    input wire evt_parity_err,
    input wire evt_serr,
    input wire evt_master_abort,
    input wire evt_target_abort_rcvd,
    input wire evt_target_abort_sig,
    input wire evt_data_parity,
    // Claim and read answer
    output reg cfg_claim,
    output reg audio_claim,
    output reg rd_valid,
    output reg [31:0] rd_data,
    // Control outputs
    output reg mem_space_en,
    output reg bus_master_en,
    output reg parity_resp_en,
    output reg serr_en,
    output reg mem_claim,
    output reg [19:0] bar0_base,
    output reg [7:0] latency_timer
);
    // Decode of the address phase
    wire dec_is_cfg;
    wire dec_write;
    wire dec_video;
    wire [3:0] dec_idx;
    wire [31:0] merged;
    wire [31:0] cur_word;
    wire cfg_hit;
    wire mem_hit;
    wire audio_hit;
    wire mem_cmd;
    wire rd_phase;
    wire data_wr;
    wire [4:0] start_idx;
    wire [4:0] next_idx;
    wire [31:0] en_lanes;
    // Write strobes of the writable doublewords
    wire wr_cmdstat;
    wire wr_hdr;
    wire wr_bar0;
    wire wr_subsys;
    wire wr_intr;
    // Status bits being cleared by software and set by bus events
    wire [15:0] w1c_clear;
    wire [15:0] w1c_set;
    // Transaction state
    reg active;
    reg is_write;
    reg [4:0] idx;
    // Registers
    reg [15:0] command;
    reg [15:0] status_w1c;
    reg [31:0] subsys;
    reg [7:0] int_line;
    reg [31:0] next_rd;
    reg [31:0] next_word;

    cfg_addr_decode u_dec (
        .idsel(idsel),
        .addr(addr),
        .cmd(cmd),
        .is_cfg(dec_is_cfg),
        .cfg_write(dec_write),
        .func_video(dec_video),
        .dword_idx(dec_idx)
    );

    byte_merge u_merge (
        .old_value(cur_word),
        .wr_data(wr_data),
        .be_n(be_n),
        .merged(merged)
    );

    // Video function claims; config decode never gated by command
    assign cfg_hit = frame_start && dec_is_cfg && dec_video;
    // Function 1 cycles are flagged for the separate audio header
    assign audio_hit = frame_start && dec_is_cfg && !dec_video;
    // Memory space kept apart by command and no select
    assign mem_cmd = (cmd == `CMD_MEM_READ) || (cmd == `CMD_MEM_WRITE);
    assign mem_hit = frame_start && !idsel && mem_cmd
        && command[`CMD_BIT_MEM] && (addr[31:12] == bar0_base);
    // Bits 7:6 kept so offsets past the header never alias onto it
    assign start_idx = {|addr[7:6], dec_idx};
    // Burst index saturates past the header rather than wrapping to zero
    assign next_idx = (idx == 5'h1F) ? idx : idx + 5'h01;
    // Data phases of a claimed read and of a claimed write
    assign rd_phase = active && data_valid && !is_write;
    assign data_wr = active && data_valid && is_write;

    // Read-back value of a header doubleword
    function [31:0] read_word;
        input [4:0] i;
        begin
            // Beyond the header nothing is implemented
            if (i >= `CFG_HDR_DWORDS) begin
                read_word = `RESET_ZERO32;
            end else begin
                case (i[3:0])
                    `CFG_IDX_ID: read_word = {DEVICE_ID, VENDOR_ID};
                    `CFG_IDX_CMDSTAT: read_word = {status_w1c | `STAT_FIXED, command};
                    // Video class code for function 0
                    `CFG_IDX_CLASS: read_word = {`CLASS_CODE, REVISION_ID};
                    // Header type in lane 2, latency in lane 1
                    `CFG_IDX_HDR: read_word = {8'h00, `HDR_TYPE_MULTI, latency_timer, 8'h00};
                    `CFG_IDX_BAR0: read_word = {bar0_base, `BAR0_LOW};
                    `CFG_IDX_SUBSYS: read_word = subsys;
                    `CFG_IDX_INTR: read_word = {`MAX_LAT, `MIN_GNT, `INT_PIN, int_line};
                    // Reserved and unsupported locations read zero
                    default: read_word = `RESET_ZERO32;
                endcase
            end
        end
    endfunction

    assign cur_word = read_word(idx);

    // Lanes enabled by the active-low byte strobes, as a bit mask
    function [31:0] lane_mask;
        input [3:0] strobes_n;
        begin
            lane_mask = {{8{~strobes_n[3]}}, {8{~strobes_n[2]}},
                {8{~strobes_n[1]}}, {8{~strobes_n[0]}}};
        end
    endfunction

    // Write phase aimed at one header doubleword; other offsets get no strobe,
    // so such writes complete with their data dropped
    function dword_write;
        input wr_phase;
        input [4:0] at;
        input [3:0] target;
        begin
            dword_write = wr_phase && (at == {1'b0, target});
        end
    endfunction

    // Lane mask and per-register write strobes
    assign en_lanes = lane_mask(be_n);
    assign wr_cmdstat = dword_write(data_wr, idx, `CFG_IDX_CMDSTAT);
    assign wr_hdr = dword_write(data_wr, idx, `CFG_IDX_HDR);
    assign wr_bar0 = dword_write(data_wr, idx, `CFG_IDX_BAR0);
    assign wr_subsys = dword_write(data_wr, idx, `CFG_IDX_SUBSYS);
    assign wr_intr = dword_write(data_wr, idx, `CFG_IDX_INTR);

    // Only enabled lanes clear, and a zero leaves its bit alone
    assign w1c_clear = wr_cmdstat ? (wr_data[31:16] & en_lanes[31:16] & `STAT_W1C_MASK)
        : 16'h0000;
    // Error and abort events; two of them only when their enable is set
    assign w1c_set = {evt_parity_err, evt_serr && serr_en, evt_master_abort,
        evt_target_abort_rcvd, evt_target_abort_sig, 2'b00,
        evt_data_parity && parity_resp_en, 8'h00};

    // Disabled lanes read back as zero so stale bits never reach the bus
    always @* begin
        next_rd = cur_word & en_lanes;
        next_word = merged;
    end

    // Transaction tracking and burst stepping
    always @(posedge clk) begin
        if (sys_rst) begin
            active <= 1'b0;
            is_write <= 1'b0;
            idx <= 5'h00;
            cfg_claim <= 1'b0;
            audio_claim <= 1'b0;
            mem_claim <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= `RESET_ZERO32;
        end else begin
            cfg_claim <= cfg_hit;
            // Function 1 lives in a separate block
            audio_claim <= audio_hit;
            mem_claim <= mem_hit;
            rd_valid <= rd_phase;
            rd_data <= rd_phase ? next_rd : `RESET_ZERO32;
            if (cfg_hit) begin
                active <= 1'b1;
                is_write <= dec_write;
                idx <= start_idx;
            end else if (active && data_valid) begin
                // Next doubleword in a burst
                idx <= next_idx;
                if (last_data) begin
                    active <= 1'b0;
                end
            end
        end
    end

    // Command bits only; read-only bits of the word are simply not stored
    always @(posedge clk) begin
        if (sys_rst) begin
            command <= 16'h0000;
        end else if (wr_cmdstat) begin
            command <= next_word[15:0] & `CMD_RW_MASK;
        end
    end

    // Status record; an event in the same cycle as its clear wins
    always @(posedge clk) begin
        if (sys_rst) begin
            status_w1c <= 16'h0000;
        end else begin
            // Clear first, then set, so a fresh event is never lost
            status_w1c <= (status_w1c & ~w1c_clear) | w1c_set;
        end
    end

    // Latency timer byte in lane 1 of its doubleword
    // Header type beside it is fixed and ignores the write
    always @(posedge clk) begin
        if (sys_rst) begin
            latency_timer <= 8'h00;
        end else if (wr_hdr) begin
            latency_timer <= next_word[15:8];
        end
    end

    // Memory base; the low twelve bits are fixed, a write to them is dropped
    always @(posedge clk) begin
        if (sys_rst) begin
            bar0_base <= 20'h00000;
        end else if (wr_bar0) begin
            bar0_base <= next_word[31:12];
        end
    end

    // Subsystem identifiers, writable at any time
    always @(posedge clk) begin
        if (sys_rst) begin
            subsys <= `RESET_ZERO32;
        end else if (wr_subsys) begin
            subsys <= next_word;
        end
    end

    // Interrupt line byte in lane 0
    // Pin, grant and latency fields beside it are fixed
    always @(posedge clk) begin
        if (sys_rst) begin
            int_line <= 8'h00;
        end else if (wr_intr) begin
            int_line <= next_word[7:0];
        end
    end

    // Enables presented from the command register
    always @(posedge clk) begin
        if (sys_rst) begin
            mem_space_en <= 1'b0;
            bus_master_en <= 1'b0;
            parity_resp_en <= 1'b0;
            serr_en <= 1'b0;
        end else begin
            // Zero command detaches all but config decode
            mem_space_en <= command[`CMD_BIT_MEM];
            bus_master_en <= command[`CMD_BIT_MASTER];
            // Error reporting enables gate two of the status events
            parity_resp_en <= command[6];
            serr_en <= command[8];
        end
    end
endmodule
`default_nettype wire

// *** sim/cfg_space_chk_assertions.sv ***
// Port-level assertions for the function 0 configuration header target
`timescale 1ns/1ps
`default_nettype none
module cfg_space_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Bus side inputs
    input wire logic frame_start,
    input wire logic idsel,
    input wire logic [31:0] addr,
    input wire logic [3:0] cmd,
    input wire logic data_valid,
    input wire logic [3:0] be_n,
    // Target answers
    input wire logic cfg_claim,
    input wire logic audio_claim,
    input wire logic rd_valid,
    input wire logic [31:0] rd_data,
    input wire logic mem_claim,
    input wire logic mem_space_en,
    input wire logic [19:0] bar0_base,
    input wire logic [7:0] latency_timer
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Config read or write with select high and a doubleword address
    wire hit = frame_start && idsel && cmd[3:1] == 3'h5 && addr[1:0] == 2'h0;
    a_video_claim: assert property (hit && addr[10:8] == 3'h0 |=> cfg_claim)
        else $error("video config cycle not claimed");
    a_claim_cause: assert property (cfg_claim |-> $past(hit && addr[10:8] == 3'h0))
        else $error("claim without a video config cycle");
    a_audio_route: assert property (hit && addr[10:8] == 3'h1
        |=> audio_claim && !cfg_claim)
        else $error("function 1 cycle routed wrongly");
    a_other_func: assert property (frame_start && addr[10:8] > 3'h1
        |=> !cfg_claim && !audio_claim)
        else $error("unimplemented function claimed");
    a_read_answer: assert property (rd_valid |-> $past(data_valid))
        else $error("read answer without a data phase");
    a_lane_zero: assert property (rd_valid && $past(be_n[3])
        |-> rd_data[31:24] == 8'h00)
        else $error("disabled lane carries data");
    a_idle_zero: assert property (!rd_valid |-> rd_data == 32'h0)
        else $error("read data not zero while idle");
    a_mem_gate: assert property (mem_claim
        |-> $past(mem_space_en && !idsel && frame_start))
        else $error("memory claim while disabled or selected");
    a_reset_clear: assert property ($fell(sys_rst) |-> !mem_space_en
        && bar0_base == 20'h0 && latency_timer == 8'h00)
        else $error("writable bits not cleared by reset");
    // Main scenarios reached
    c_claim: cover property (cfg_claim);
    c_read: cover property (rd_valid && rd_data != 32'h0);
    c_mem: cover property (mem_claim);
endmodule
bind pci_config_space_decode cfg_space_chk u_chk (.clk(clk), .sys_rst(sys_rst),
    .frame_start(frame_start), .idsel(idsel), .addr(addr), .cmd(cmd), .data_valid(data_valid),
    .be_n(be_n), .cfg_claim(cfg_claim), .audio_claim(audio_claim), .rd_valid(rd_valid),
    .rd_data(rd_data), .mem_claim(mem_claim), .mem_space_en(mem_space_en),
    .bar0_base(bar0_base), .latency_timer(latency_timer));
`default_nettype wire

// *** sim/cfg_host.sv ***
// Host bridge model issuing configuration and memory cycles
`timescale 1ns/1ps
`default_nettype none
module cfg_host (
    // Clock
    input wire logic clk,
    // Requests toward the target
    output logic frame_start,
    output logic idsel,
    output logic [31:0] addr,
    output logic [3:0] cmd,
    output logic data_valid,
    output logic last_data,
    output logic [31:0] wr_data,
    output logic [3:0] be_n,
    // Answers from the target
    input wire logic cfg_claim,
    input wire logic audio_claim,
    input wire logic mem_claim,
    input wire logic rd_valid,
    input wire logic [31:0] rd_data
);
    logic [31:0] wq[$];
    logic [31:0] rq[$];
    int cc, ac, mc;
    initial begin
        {frame_start, data_valid, last_data, idsel, cmd, be_n} = 0;
        {addr, wr_data} = 0;
    end
    // One-cycle answers are taken at the edge where they stand
    always @(posedge clk) begin
        cc <= cc + cfg_claim;
        ac <= ac + audio_claim;
        mc <= mc + mem_claim;
        if (rd_valid) rq.push_back(rd_data);
    end
    // Released lines flip so a stale value never looks valid
    task automatic xfer(input logic [31:0] a, input logic [3:0] c, input logic id,
                        input int n, input logic [3:0] be);
        @(negedge clk);
        {cc, ac, mc} = 0;
        rq.delete();
        frame_start = 1;
        idsel = id;
        addr = a;
        cmd = c;
        @(negedge clk);
        frame_start = 0;
        idsel = ~id;
        addr = ~addr;
        for (int k = 0; k < n; k++) begin
            data_valid = 1;
            last_data = (k == n - 1);
            be_n = be;
            wr_data = (c[0] && wq.size() > 0) ? wq.pop_front() : ~wr_data;
            @(negedge clk);
        end
        data_valid = 0;
        last_data = 0;
        wr_data = ~wr_data;
        repeat (3) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// *** sim/test_pci_config_space_decode.sv ***
// Self-checking bench for the function 0 configuration header target
`timescale 1ns/1ps
`default_nettype none
module test_pci_config_space_decode;
    logic clk = 0;
    logic sys_rst = 1;
    logic [5:0] ev = 0;
    logic frame_start, idsel, data_valid, last_data, cfg_claim, audio_claim, rd_valid, mem_claim;
    logic mem_space_en, bus_master_en, parity_resp_en, serr_en;
    logic [31:0] addr, wr_data, rd_data;
    logic [3:0] cmd, be_n;
    logic [19:0] bar0_base;
    logic [7:0] latency_timer;
    logic [31:0] m[16];
    logic [31:0] wm[16];
    int err_count = 0;
    int checks_done = 0;
    always #10 clk = ~clk;
    // Default identity parameters are arbitrary
    pci_config_space_decode uut (.clk(clk), .sys_rst(sys_rst), .frame_start(frame_start),
        .idsel(idsel), .addr(addr), .cmd(cmd), .data_valid(data_valid), .last_data(last_data),
        .wr_data(wr_data), .be_n(be_n), .evt_parity_err(ev[0]), .evt_serr(ev[1]),
        .evt_master_abort(ev[2]), .evt_target_abort_rcvd(ev[3]), .evt_target_abort_sig(ev[4]),
        .evt_data_parity(ev[5]), .cfg_claim(cfg_claim), .audio_claim(audio_claim),
        .rd_valid(rd_valid), .rd_data(rd_data), .mem_space_en(mem_space_en),
        .bus_master_en(bus_master_en), .parity_resp_en(parity_resp_en), .serr_en(serr_en),
        .mem_claim(mem_claim), .bar0_base(bar0_base), .latency_timer(latency_timer));
    cfg_host host (.clk(clk), .frame_start(frame_start), .idsel(idsel), .addr(addr),
        .cmd(cmd), .data_valid(data_valid), .last_data(last_data), .wr_data(wr_data),
        .be_n(be_n), .cfg_claim(cfg_claim), .audio_claim(audio_claim), .mem_claim(mem_claim),
        .rd_valid(rd_valid), .rd_data(rd_data));
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] lm(input logic [3:0] b);
        return {{8{~b[3]}}, {8{~b[2]}}, {8{~b[1]}}, {8{~b[0]}}};
    endfunction
    // Header image after reset and the writable bits of each doubleword
    task automatic minit();
        foreach (m[i]) begin
            m[i] = 32'h0;
            wm[i] = 32'h0;
        end
        m[0] = 32'h1234ABCD;
        m[1] = 32'h02800000;
        m[2] = 32'h04000001;
        m[3] = 32'h00800000;
        m[4] = 32'h00000008;
        m[15] = 32'h50100100;
        wm[1] = 32'h00000146;
        wm[3] = 32'h0000FF00;
        wm[4] = 32'hFFFFF000;
        wm[8] = 32'hFFFFFFFF;
        wm[15] = 32'h000000FF;
    endtask
    task automatic outs();
        chk({mem_space_en, bus_master_en, parity_resp_en, serr_en},
            {m[1][1], m[1][2], m[1][6], m[1][8]});
        chk(bar0_base, m[4][31:12]);
        chk(latency_timer, m[3][15:8]);
    endtask
    task automatic cyc(input logic [31:0] a, input logic [3:0] c, input logic id, input int n,
                       input logic [3:0] be, input int ec, input int ea = 0, input int em = 0);
        host.xfer(a, c, id, n, be);
        chk(host.cc, ec);
        chk(host.ac, ea);
        chk(host.mc, em);
        chk(host.rq.size(), c[0] ? 0 : ec * n);
    endtask
    task automatic rd(input logic [31:0] a, input int n, input logic [3:0] be);
        int o;
        cyc(a, 4'hA, 1'b1, n, be, 1);
        for (int k = 0; k < n; k++) begin
            o = a[7:2] + k;
            chk(host.rq[k], o < 16 ? m[o] & lm(be) : 32'h0);
        end
        outs();
    endtask
    task automatic wr(input logic [31:0] a, input int n, input logic [3:0] be,
                      input logic [31:0] d, input bit rnd);
        logic [31:0] v, l;
        int o;
        l = lm(be);
        for (int k = 0; k < n; k++) begin
            v = rnd ? $urandom : d;
            host.wq.push_back(v);
            o = a[7:2] + k;
            if (o == 1) m[1] = m[1] & ~(v & l & 32'hF9000000);
            if (o < 16) m[o] = m[o] & ~(wm[o] & l) | v & wm[o] & l;
        end
        cyc(a, 4'hB, 1'b1, n, be, 1);
    endtask
    // Hang guard, far beyond the few hundred cycles the run needs
    initial begin
        #200000;
        err_count++;
        wrap_up();
    end
    initial begin
        void'($urandom(98));
        repeat (3) @(negedge clk);
        sys_rst = 0;
        minit();
        outs();
        rd(32'h0, 16, 4'h0);
        rd(32'h40, 2, 4'h0); // Beyond the header
        repeat (8) begin
            wr($urandom & 32'h3C, $urandom_range(16, 1), 4'($urandom), 32'h0, 1);
            rd($urandom & 32'h7C, $urandom_range(16, 1), 4'($urandom));
        end
        // Mid-run reset returns every writable bit to zero
        sys_rst = 1;
        repeat (3) @(negedge clk);
        sys_rst = 0;
        minit();
        outs();
        rd(32'h0, 16, 4'h0);
        // Status events, then clear one bit with a single lane
        wr(32'h4, 1, 4'h0, 32'h00000146, 0);
        @(negedge clk) ev = 6'h3F;
        @(negedge clk) ev = 6'h00;
        m[1] = m[1] | 32'hF9000000;
        wr(32'h4, 1, 4'h7, 32'h08000000, 0);
        rd(32'h4, 1, 4'h0);
        // Refused and rerouted cycles
        cyc(32'h1, 4'hA, 1'b1, 1, 4'h0, 0);
        cyc(32'h0, 4'hA, 1'b0, 1, 4'h0, 0);
        cyc(32'h200, 4'hA, 1'b1, 1, 4'h0, 0);
        cyc(32'h704, 4'hB, 1'b1, 1, 4'h0, 0);
        cyc(32'h100, 4'hA, 1'b1, 0, 4'h0, 0, 1);
        // Memory decode against the base, then with the command cleared
        wr(32'h10, 1, 4'h0, 32'hABCDE000, 0);
        cyc(32'hABCDE010, 4'h6, 1'b0, 0, 4'h0, 0, 0, 1);
        cyc(32'hABCDE010, 4'h6, 1'b1, 0, 4'h0, 0, 0, 0);
        cyc(32'h12345010, 4'h6, 1'b0, 0, 4'h0, 0, 0, 0);
        wr(32'h4, 1, 4'h0, 32'h0, 0);
        cyc(32'hABCDE010, 4'h6, 1'b0, 0, 4'h0, 0, 0, 0);
        rd(32'h0, 3, 4'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
